// ---- src/acs_pkg.sv ----
// Package for the bus clock-enable stall control block
package acs_pkg;
    // Bus word width
    localparam int ACS_DATA_W = 32;
    // Bus address width
    localparam int ACS_ADDR_W = 32;
    // Reset value of the core clock enable (core runs after reset)
    localparam logic ACS_CORE_EN_RST = 1'b1;
    // Reset value of the launched-transfer flag
    localparam logic ACS_LAUNCH_RST = 1'b0;

    // Bus sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_SYNC,
        ACS_DATA
    } acs_state_t;

    // Core request toward the bus
    typedef struct packed {
        logic valid;
        logic write;
        logic [ACS_ADDR_W-1:0] addr;
        logic [ACS_DATA_W-1:0] wdata;
    } acs_req_t;

    // Address and control driven onto the bus
    typedef struct packed {
        logic active;
        logic write;
        logic [ACS_ADDR_W-1:0] addr;
        logic [ACS_DATA_W-1:0] wdata;
    } acs_bus_t;
endpackage : acs_pkg

// ---- src/acs_rst_sync.sv ----
// Two-stage reset release synchroniser
module acs_rst_sync (
    // Clock and raw reset
    input wire logic mclk,
    input wire logic rst_n,
    // Synchronised reset
    output logic rst_sync_n
);
    import acs_pkg::*;

    logic [1:0] sync_q;

    // Assert at once, release after two edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 2'h0;
        end else begin
            sync_q <= {sync_q[0], 1'b1};
        end
    end

    assign rst_sync_n = sync_q[1];
endmodule // acs_rst_sync

// ---- src/acs_stall_ctrl.sv ----
// Bus interface stall control: fast core clock, bus timed by an edge enable
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R1] Everything runs on mclk; bus via enable
// [R2] System marks shared bus edges with enable
// [R3] Decoupled traffic ignores enable and ready
// [R4] Decoupled stalls: memory stalls, buffer overflow only
// [R5] Bus read/unbuffered write stalls until done
// [R6] Launch address only when enable high
// [R7] Stall until next enable before launch
// [R8] Done only when ready AND enable
// [R9] Release core enable on completion
// [R10] Sync stall at most ratio minus one
// [R11] Slow slave holds ready low
// [R12] Low ready stretches data and next address
// [R13] Capture read data at completion edge
module acs_stall_ctrl #(
    parameter int RATIO_MAX = 8 // Largest fast-to-bus clock ratio checked
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bus timing inputs
    input wire logic bus_edge_enable,
    input wire logic hready,
    // Core side
    input wire acs_pkg::acs_req_t core_req,
    input wire logic tcm_stall,
    input wire logic wbuf_full,
    output logic core_clock_enable,
    output logic [acs_pkg::ACS_DATA_W-1:0] core_rdata,
    // Bus side
    input wire logic [acs_pkg::ACS_DATA_W-1:0] hrdata,
    output acs_pkg::acs_bus_t bus_out
);
    import acs_pkg::*;

    // All state in one packed struct
    typedef struct packed {
        acs_state_t state;
        logic core_en;
        acs_bus_t bus;
        logic [ACS_DATA_W-1:0] rdata;
        logic [7:0] sync_cnt; // Cycles spent waiting for a bus edge
    } acs_regs_t;

    acs_regs_t r_q; // Registered state
    acs_regs_t r_d; // Next state
    logic rst_sync_n; // Released reset
    logic bus_edge; // Bus edge marker as seen this cycle
    logic bus_rdy; // Ready as seen this cycle
    logic done; // Transfer completion

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    acs_rst_sync u_rst (
        .mclk(mclk),
        .rst_n(rst_n),
        .rst_sync_n(rst_sync_n)
    );

    // Enable and ready come from bus logic on this same clock, so they are
    // used as they stand: a delayed copy would launch and complete the
    // transfer off the real bus edges
    assign bus_edge = bus_edge_enable; // R6
    assign bus_rdy = hready;

    // Completion needs both ready and bus edge
    assign done = bus_rdy & bus_edge; // R8

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        r_d = r_q;
        // Count cycles spent waiting for a bus edge
        r_d.sync_cnt = (r_q.state == ACS_SYNC) ? r_q.sync_cnt + 8'h01 : 8'h00;
        case (r_q.state)
            ACS_IDLE: begin
                if (core_req.valid) begin
                    // Bus access: drop core enable at once
                    r_d.core_en = 1'b0; // R5
                    if (bus_edge) begin
                        r_d.bus = {1'b1, core_req.write, core_req.addr, core_req.wdata}; // R6
                        r_d.state = ACS_DATA;
                    end else begin
                        r_d.state = ACS_SYNC; // R7
                    end
                end else begin
                    // Decoupled: only local stalls count, never bus inputs
                    r_d.core_en = ~(tcm_stall | wbuf_full); // R3 R4
                end
            end
            ACS_SYNC: begin
                // Wait for a bus edge before launching
                if (bus_edge) begin
                    r_d.bus = {1'b1, core_req.write, core_req.addr, core_req.wdata}; // R6 R7
                    r_d.state = ACS_DATA;
                end
            end
            ACS_DATA: begin
                // Low ready stretches the data phase
                if (done) begin // R12
                    r_d.bus.active = 1'b0;
                    // Reads take the bus word at the completing edge
                    r_d.rdata = r_q.bus.write ? r_q.rdata : hrdata; // R13
                    r_d.core_en = 1'b1; // R9
                    r_d.state = ACS_IDLE;
                end
            end
            default: begin
                r_d.state = ACS_IDLE;
            end
        endcase
    end

    // Read data is held until the next read; a write leaves it alone, so the
    // core still sees its last load across stores. The word is only valid
    // at the edge where ready and the bus edge meet, so no other edge samples it

    ////////////////////////////////////////////////////////////////////////////
    // State register, all on mclk
    always_ff @(posedge mclk or negedge rst_sync_n) begin // R1
        if (!rst_sync_n) begin
            r_q.state <= ACS_IDLE;
            r_q.core_en <= ACS_CORE_EN_RST;
            r_q.bus <= '0;
            r_q.rdata <= '0;
            r_q.sync_cnt <= 8'h00;
        end else begin
            r_q <= r_d;
        end
    end

    assign core_clock_enable = r_q.core_en;
    assign core_rdata = r_q.rdata;
    assign bus_out = r_q.bus;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // The wait for a bus edge is counted in the state struct itself

    property p_launch_on_edge;
        @(posedge mclk) disable iff (!rst_sync_n)
        $rose(r_q.bus.active) |-> $past(bus_edge);
    endproperty
    a_launch_on_edge: assert property (p_launch_on_edge) else $error("launch off edge"); // R6

    property p_done_and;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_DATA && !(bus_rdy && bus_edge)) |=> r_q.state == ACS_DATA;
    endproperty
    a_done_and: assert property (p_done_and) else $error("early completion"); // R8

    property p_release;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_DATA && done) |=> core_clock_enable && !bus_out.active;
    endproperty
    a_release: assert property (p_release) else $error("core not released"); // R9

    property p_stall_held;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state != ACS_IDLE) |-> !core_clock_enable;
    endproperty
    a_stall_held: assert property (p_stall_held) else $error("core ran in transfer"); // R5

    property p_sync_bound;
        @(posedge mclk) disable iff (!rst_sync_n)
        r_q.sync_cnt < 8'(RATIO_MAX);
    endproperty
    a_sync_bound: assert property (p_sync_bound) else $error("sync stall too long"); // R10

    property p_decoupled;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_IDLE && !core_req.valid) |=>
            core_clock_enable == !($past(tcm_stall) || $past(wbuf_full));
    endproperty
    a_decoupled: assert property (p_decoupled) else $error("bad decoupled stall"); // R3 R4

    property p_edge_wait;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_SYNC && !bus_edge) |=> r_q.state == ACS_SYNC;
    endproperty
    a_edge_wait: assert property (p_edge_wait) else $error("left sync early"); // R7

    property p_req_stalls;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_IDLE && core_req.valid) |=> !core_clock_enable;
    endproperty
    a_req_stalls: assert property (p_req_stalls) else $error("no stall on request"); // R5

    property p_take_on_edge;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_IDLE && core_req.valid && bus_edge) |=>
            bus_out.active && bus_out.addr == $past(core_req.addr);
    endproperty
    a_take_on_edge: assert property (p_take_on_edge) else $error("no launch on edge"); // R6

    property p_sync_no_launch;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_SYNC && !bus_edge) |=> !bus_out.active;
    endproperty
    a_sync_no_launch: assert property (p_sync_no_launch) else $error("launch before edge"); // R7

    property p_decoupled_no_bus;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_IDLE && !core_req.valid) |=> !bus_out.active;
    endproperty
    a_decoupled_no_bus: assert property (p_decoupled_no_bus) else $error("bus used idle"); // R3

    property p_bus_hold;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_DATA && !done) |=> $stable(bus_out);
    endproperty
    a_bus_hold: assert property (p_bus_hold) else $error("bus moved in wait"); // R12

    property p_rdata_capture;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_DATA && done && !r_q.bus.write) |=> core_rdata == $past(hrdata);
    endproperty
    a_rdata_capture: assert property (p_rdata_capture) else $error("read word lost"); // R13

    property p_write_keeps_rdata;
        @(posedge mclk) disable iff (!rst_sync_n)
        (r_q.state == ACS_DATA && r_q.bus.write) |=> $stable(core_rdata);
    endproperty
    a_write_keeps_rdata: assert property (p_write_keeps_rdata) else $error("read word hit"); // R13
endmodule // acs_stall_ctrl

// ---- test/acs_ahb_slave.sv ----
// Bus-side model: bus edge enable generator and wait-stating slave
module acs_ahb_slave (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Test controls: fast-to-bus ratio and wait states
    input wire logic [3:0] ratio,
    input wire logic [3:0] waits,
    // Bus from the design
    input wire acs_pkg::acs_bus_t bus_out,
    // Bus timing and read data toward the design
    output logic bus_edge_enable,
    output logic hready,
    output logic [acs_pkg::ACS_DATA_W-1:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ns;
    import acs_pkg::*;

    logic [3:0] phase_q; // Fast cycles since the last bus edge
    logic [3:0] wait_q; // Wait states still owed
    // One enabled fast edge in every ratio
    assign bus_edge_enable = (phase_q == 4'h0);
    // Ready low while waits remain, so the data phase stretches
    assign hready = !(bus_out.active && wait_q != 4'h0);
    // Read word shows only once the waits are spent and is zero otherwise,
    // so a capture at the wrong edge is seen
    assign hrdata = (bus_out.active && wait_q == 4'h0) ?
        {bus_out.addr[15:0], bus_out.addr[31:16]} : '0;
    // Wait count reloads on any cycle while the bus is idle and counts down only on bus edges
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 4'h0;
            wait_q <= 4'h0;
        end else begin
            phase_q <= (phase_q + 4'h1 >= ratio) ? 4'h0 : phase_q + 4'h1;
            if (!bus_out.active) begin
                wait_q <= waits;
            end else if (bus_edge_enable && wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
        end
    end
endmodule // acs_ahb_slave

// ---- test/acs_stall_ctrl_test.sv ----
// Self-checking testbench for the bus stall control block
module acs_stall_ctrl_test;
    timeunit 1ns;
    timeprecision 1ns;
    import acs_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, tcm_stall = 1'b0, wbuf_full = 1'b0;
    logic bus_edge_enable, hready, core_clock_enable;
    logic [3:0] ratio = 4'h3, waits = 4'h0; // Bus model settings
    logic [ACS_DATA_W-1:0] core_rdata;
    logic [ACS_DATA_W-1:0] hrdata; // Read word from the bus model
    logic [31:0] last_rd = 32'h0; // Last word read, kept across writes
    acs_req_t core_req = '0;
    acs_bus_t bus_out;
    int n_errors = 0, compares = 0;
    // 20 MHz fast clock
    always #25 mclk = ~mclk;
    acs_stall_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .bus_edge_enable(bus_edge_enable),
        .hready(hready), .core_req(core_req), .tcm_stall(tcm_stall), .wbuf_full(wbuf_full),
        .core_clock_enable(core_clock_enable), .core_rdata(core_rdata), .hrdata(hrdata),
        .bus_out(bus_out));
    acs_ahb_slave i_slave (.mclk(mclk), .rst_n(rst_n), .ratio(ratio), .waits(waits),
        .bus_out(bus_out), .bus_edge_enable(bus_edge_enable), .hready(hready),
        .hrdata(hrdata));
    ////////////////////////////////////////////////////////////////////////////
    // One comparison, counted
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Local stalls only; bus is slow and idle, so the core must run free
    task automatic decoupled();
        @(posedge mclk) ratio <= 4'h8;
        tcm_stall <= 1'b1;
        repeat (4) @(negedge mclk);
        chk("tcm_stall", 0, core_clock_enable);
        @(posedge mclk) tcm_stall <= 1'b0;
        wbuf_full <= 1'b1;
        repeat (4) @(negedge mclk);
        chk("wbuf_full", 0, core_clock_enable);
        @(posedge mclk) wbuf_full <= 1'b0;
        repeat (4) @(negedge mclk);
        chk("free_run", 1, core_clock_enable);
        chk("no_bus", 0, bus_out.active);
    endtask
    // One stalling bus transfer at a given ratio and wait count
    task automatic xfer(logic wr, logic [31:0] a, int r, int w);
        int n;
        logic [31:0] rd_exp;
        // Let the bus model settle on the new ratio before the core asks
        @(posedge mclk) ratio <= 4'(r);
        waits <= 4'(w);
        @(posedge mclk) core_req <= '{1'b1, wr, a, ~a};
        n = 0;
        @(negedge mclk);
        while (bus_out.active !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        chk("launch_wait", 1, n <= r);
        chk("bus_addr", a, bus_out.addr);
        chk("bus_write", wr, bus_out.write);
        chk("bus_wdata", ~a, bus_out.wdata);
        chk("core_stall", 0, core_clock_enable);
        // Once launched the request is no longer read; dropping it here keeps
        // the block from taking it a second time after release
        @(posedge mclk) core_req.valid <= 1'b0;
        n = 1;
        @(negedge mclk);
        while (core_clock_enable !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk("data_phase", (w + 1) * r, n);
        chk("resume", 1, core_clock_enable);
        chk("bus_released", 0, bus_out.active);
        rd_exp = wr ? last_rd : {a[15:0], a[31:16]};
        chk("core_rdata", rd_exp, core_rdata);
        last_rd = rd_exp;
        repeat (2) @(negedge mclk);
        chk("no_relaunch", 0, bus_out.active);
        chk("core_runs", 1, core_clock_enable);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        decoupled();
        for (int r = 1; r <= 4; r++) begin
            for (int w = 0; w <= 2; w++) begin
                xfer(1'(w), 32'h1000_0000 + 32'(r * 16 + w), r, w);
            end
        end
        close_out();
    end
    // Watchdog against a hung handshake
    initial begin
        #(50 * 20000);
        n_errors++;
        close_out();
    end
endmodule // acs_stall_ctrl_test
